//--- core/dpot_i2c_regs.v
// I2C slave and register logic for a single 128-tap digital pot
`timescale 1ns/10ps
`include "dpot_map.vh"
module dpot_i2c_regs #(
  parameter NVW_CYCLES = `DPOT_NVW_CYC,
  parameter PWRUP_CYC  = `DPOT_PWRUP_CYC
) (
  input  wire       core_clk_i,
  input  wire       rstn_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output wire       sda_o,
  output wire       sda_oe_o,
  input  wire       addr_pin_high_i,
  input  wire       addr_pin_low_i,
  input  wire       shutdown_n_i,
  output reg  [6:0] wiper_o,
  output reg        shutdown_o,
  output wire       nv_write_busy_o
);
  localparam ST_IDLE  = 3'd0;
  localparam ST_RX    = 3'd1;
  localparam ST_ACK   = 3'd2;
  localparam ST_TX    = 3'd3;
  localparam ST_MACK  = 3'd4;

  localparam PH_ID    = 2'd0;
  localparam PH_ADDR  = 2'd1;
  localparam PH_DATA  = 2'd2;

  reg  [2:0] state_reg;
  reg  [1:0] phase_reg;
  reg  [2:0] bit_reg;
  reg  [7:0] shift_reg;
  reg  [7:0] addr_reg;
  reg  [7:0] wiper_reg;
  reg  [7:0] nv_reg;
  reg        vol_reg;
  reg        pdc_reg;
  reg        nv_pend_reg;
  reg        drive_reg;
  reg        scl_d_reg;
  reg        sda_d_reg;
  reg  [4:0] pwr_cnt_reg;
  reg        pwr_ok_reg;
  reg        mack_reg;
  reg        wr_stb_reg;
  reg  [7:0] wr_data_reg;
  wire       nv_busy;
  wire       nv_kick;
  wire [7:0] tx_value;

  wire scl_rise = scl_i & ~scl_d_reg;
  wire scl_fall = ~scl_i & scl_d_reg;
  wire start_c  = scl_i & scl_d_reg & sda_d_reg & ~sda_i;
  wire stop_c   = scl_i & scl_d_reg & ~sda_d_reg & sda_i;
  wire [7:0] rx_byte = {shift_reg[6:0], sda_i};

  function id_match;
    input [7:0] b;
    input       ah;
    input       al;
    begin
      id_match = (b[7:3] == `DPOT_ID_PREFIX) && (b[2] == ah) && (b[1] == al);
    end
  endfunction

  function [7:0] read_value;
    input [7:0] a;
    input       volatile_select;
    input [7:0] wr;
    input [7:0] nv;
    input [7:0] access_control;
    begin
      case (a)
        `DPOT_ADDR_WIPER: read_value = volatile_select ? wr : nv;
        `DPOT_ADDR_ACR:   read_value = access_control;
        default:          read_value = 8'h00;
      endcase
    end
  endfunction

  function [2:0] bit_inc;
    input [2:0] b;
    begin
      bit_inc = b + 3'd1;
    end
  endfunction

  function [1:0] next_phase;
    input [1:0] p;
    begin
      case (p)
        PH_ID:   next_phase = PH_ADDR;
        default: next_phase = PH_DATA;
      endcase
    end
  endfunction

  wire [7:0] acr_value = {vol_reg, pdc_reg, nv_busy, 5'h00};

  // Latched address, no auto-increment: every byte repeats
  assign tx_value = read_value(addr_reg, vol_reg, wiper_reg, nv_reg,
                               acr_value);

  // NV write kicks once we are back in idle: after a stop, a master NACK or an ID mismatch
  assign nv_kick = nv_pend_reg & (state_reg == ST_IDLE);

  dpot_nv_timer #(
    .CYCLES (NVW_CYCLES),
    .CW     (20)
  ) u_nvt (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .start_i    (nv_kick),
    .busy_o     (nv_busy),
    .done_o     ()
  );

  // Power-up window: starts ignored and wiper held mid-scale
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pwr_cnt_reg <= 5'h00;
      pwr_ok_reg  <= 1'b0;
    end else if (!pwr_ok_reg) begin
      pwr_cnt_reg <= pwr_cnt_reg + 5'h01;
      if (pwr_cnt_reg == PWRUP_CYC[4:0])
        pwr_ok_reg <= 1'b1;
    end
  end

  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_i;
      sda_d_reg <= sda_i;
    end
  end

  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg   <= ST_IDLE;
      phase_reg   <= PH_ID;
      bit_reg     <= 3'd0;
      shift_reg   <= 8'h00;
      addr_reg    <= 8'h00;
      mack_reg    <= 1'b0;
      wr_stb_reg  <= 1'b0;
      wr_data_reg <= 8'h00;
      drive_reg   <= 1'b0;
    end else begin
      wr_stb_reg <= 1'b0;
      if (!pwr_ok_reg) begin
        state_reg <= ST_IDLE;
      end else if (start_c) begin
        // Repeated start keeps the latched address
        state_reg <= ST_RX;
        phase_reg <= PH_ID;
        bit_reg   <= 3'd0;
        mack_reg  <= 1'b0;
        drive_reg <= 1'b0;
      end else if (stop_c) begin
        state_reg <= ST_IDLE;
        drive_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: drive_reg <= 1'b0;
          ST_RX: if (scl_rise) begin
            shift_reg <= rx_byte;
            bit_reg   <= bit_inc(bit_reg);
            if (bit_reg == 3'd7) begin
              state_reg <= ST_ACK;
              case (phase_reg)
                PH_ID: if (!id_match(rx_byte, addr_pin_high_i,
                                     addr_pin_low_i))
                  state_reg <= ST_IDLE;
                PH_ADDR: addr_reg <= rx_byte;
                default: begin
                  // Register file takes it on the next clock
                  wr_stb_reg  <= 1'b1;
                  wr_data_reg <= rx_byte;
                end
              endcase
            end
          end
          ST_ACK: begin
            // Drive ack on the low phase after the eighth bit
            if (scl_fall && !drive_reg)
              drive_reg <= 1'b1;
            else if (scl_fall && drive_reg) begin
              drive_reg <= 1'b0;
              bit_reg   <= 3'd0;
              if (phase_reg == PH_ID && shift_reg[0]) begin
                state_reg <= ST_TX;
                shift_reg <= tx_value;
                drive_reg <= ~tx_value[7];
              end else begin
                state_reg <= ST_RX;
                phase_reg <= next_phase(phase_reg);
              end
            end
          end
          ST_TX: if (scl_fall) begin
            bit_reg <= bit_inc(bit_reg);
            if (bit_reg == 3'd7) begin
              drive_reg <= 1'b0;
              state_reg <= ST_MACK;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              drive_reg <= ~shift_reg[6];
            end
          end
          ST_MACK: if (scl_rise) begin
            if (sda_i)
              state_reg <= ST_IDLE;
            else
              mack_reg  <= 1'b1;
          end else if (scl_fall && mack_reg) begin
            // Master acked: reload and put the MSB out again
            mack_reg  <= 1'b0;
            state_reg <= ST_TX;
            bit_reg   <= 3'd0;
            shift_reg <= tx_value;
            drive_reg <= ~tx_value[7];
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // Register file, one write per data byte taken while no NV write is busy
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wiper_reg   <= {1'b0, `DPOT_WIPER_MID};
      nv_reg      <= `DPOT_NV_RST;
      vol_reg     <= `DPOT_VOL_RST;
      pdc_reg     <= `DPOT_PDC_RST;
      nv_pend_reg <= 1'b0;
    end else if (!pwr_ok_reg) begin
      wiper_reg <= {1'b0, `DPOT_WIPER_MID};
      if (pwr_cnt_reg == PWRUP_CYC[4:0])
        wiper_reg <= nv_reg;
    end else begin
      if (nv_busy)
        nv_pend_reg <= 1'b0;
      // Dropped, not deferred: the byte is still acked
      if (wr_stb_reg && !nv_busy) begin
        case (addr_reg)
          `DPOT_ADDR_WIPER: begin
            wiper_reg <= {1'b0, wr_data_reg[6:0]};
            if (!vol_reg) begin
              nv_reg      <= {1'b0, wr_data_reg[6:0]};
              nv_pend_reg <= 1'b1;
            end
          end
          `DPOT_ADDR_ACR: begin
            vol_reg <= wr_data_reg[`DPOT_ACR_VOL_BIT];
            pdc_reg <= wr_data_reg[`DPOT_ACR_PDC_BIT];
          end
          default: ;
        endcase
      end
    end
  end

  // Either the pin or the bit forces shutdown
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      shutdown_o <= 1'b1;
    else
      shutdown_o <= ~(shutdown_n_i & pdc_reg);
  end

  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      wiper_o <= `DPOT_WIPER_MID;
    else
      wiper_o <= wiper_reg[6:0];
  end

  // Busy only while the self-timed write runs, as the control bit
  assign nv_write_busy_o = nv_busy;

  // Open drain: only ever pulls low
  assign sda_o    = 1'b0;
  assign sda_oe_o = drive_reg & pwr_ok_reg;
endmodule

//--- core/dpot_map.vh
// Register map, field positions, reset values and timing counts
`ifndef DPOT_MAP_VH
`define DPOT_MAP_VH
`define DPOT_ADDR_WIPER      8'h00
`define DPOT_ADDR_RSVD       8'h01
`define DPOT_ADDR_ACR        8'h02
`define DPOT_ACR_VOL_BIT     7
`define DPOT_ACR_PDC_BIT     6
`define DPOT_ACR_BUSY_BIT    5
`define DPOT_VOL_RST         1'b0
`define DPOT_PDC_RST         1'b1
`define DPOT_WIPER_MID       7'h40
`define DPOT_NV_RST          8'h40
// Device-type prefix of the ID byte; value is arbitrary
`define DPOT_ID_PREFIX       5'h13
`define DPOT_CLK_HZ          25000000
`define DPOT_NVW_TIME_MS     20
`define DPOT_NVW_CYC         ((`DPOT_CLK_HZ / 1000) * `DPOT_NVW_TIME_MS)
`define DPOT_PWRUP_CYC       16
`endif

//--- core/dpot_nv_timer.v
// Self-timed non-volatile write cycle counter
`timescale 1ns/10ps
`include "dpot_map.vh"
module dpot_nv_timer #(
  parameter CYCLES = `DPOT_NVW_CYC,
  parameter CW     = 20
) (
  input  wire core_clk_i,
  input  wire rstn_i,
  input  wire start_i,
  output wire busy_o,
  output wire done_o
);
  reg [CW-1:0] cnt_reg;
  reg          busy_reg;
  wire         last = (cnt_reg == CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1});

  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg  <= {CW{1'b0}};
      busy_reg <= 1'b0;
    end else if (start_i && !busy_reg) begin
      cnt_reg  <= {CW{1'b0}};
      busy_reg <= 1'b1;
    end else if (busy_reg) begin
      if (last)
        busy_reg <= 1'b0;
      cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  assign busy_o = busy_reg;
  assign done_o = busy_reg & last;
endmodule

//--- bench/pot_mst.sv
// I2C master model for the pot slave bench
`timescale 1ns/10ps
module pot_mst (
  input  wire core_clk_i,
  input  wire sda_i,
  output reg  scl_o = 1'b1,
  output reg  sda_low_o = 1'b0
);
  task px(input s, input d); begin
    scl_o <= s;
    sda_low_o <= !d;
    repeat (4) @(posedge core_clk_i);
  end endtask
  task bt(input d, output r); begin
    px(1'b0, !sda_low_o);
    px(1'b0, d);
    px(1'b1, d);
    r = sda_i;
  end endtask
  // Start when p is 0, stop when p is 1
  task cnd(input p); begin
    px(1'b0, !sda_low_o);
    px(1'b0, !p);
    px(1'b1, !p);
    px(1'b1, p);
  end endtask
  task by(input [7:0] b, input m, output [7:0] r, output k);
    integer i;
    begin
    for (i = 7; i >= 0; i = i - 1)
      bt(b[i], r[i]);
    bt(m, k);
    k = !k;
  end endtask
  task xfer(input [7:0] id, a, d, input w, output [15:0] v, output ok);
    reg k0, k1, k2, x;
    begin
    cnd(1'b0);
    by(id, 1'b1, v[7:0], k0);
    by(a, 1'b1, v[7:0], k1);
    if (w) by(d, 1'b1, v[7:0], k2);
    else begin
      cnd(1'b0);
      by(id | 8'h01, 1'b1, v[7:0], k2);
      by(8'hff, 1'b0, v[15:8], x);
      by(8'hff, 1'b1, v[7:0], x);
    end
    cnd(1'b1);
    ok = k0 & k1 & k2;
  end endtask
endmodule

//--- bench/pot_i2c_slave_regs_sva.sv
// Port assertions for the pot I2C slave
`timescale 1ns/10ps
module pot_i2c_slave_regs_sva #(
  parameter NVW_CYCLES = 2000,
  parameter PWRUP_CYC  = 16
) (
  input wire       core_clk_i,
  input wire       rstn_i,
  input wire       scl_i,
  input wire       sda_i,
  input wire       sda_o,
  input wire       sda_oe_o,
  input wire       addr_pin_high_i,
  input wire       addr_pin_low_i,
  input wire       shutdown_n_i,
  input wire [6:0] wiper_o,
  input wire       shutdown_o,
  input wire       nv_write_busy_o
);
  reg [7:0]  pc;
  reg [15:0] bc;
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pc <= 8'h00;
      bc <= 16'h0000;
    end else begin
      pc <= pc + {7'h00, pc != 8'hff};
      bc <= nv_write_busy_o ? bc + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  drain_zero_a: assert property (sda_o == 1'b0)
    else $error("sda_o not low");
  quiet_pwrup_a: assert property
    (pc < PWRUP_CYC |-> !sda_oe_o && wiper_o == 7'h40)
    else $error("power-up state");
  oe_scl_low_a: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("sda moved, scl high");
  oe_bound_a: assert property
    ($rose(sda_oe_o) |-> ##[1:120] !sda_oe_o)
    else $error("sda held too long");
  pin_shut_a: assert property (!shutdown_n_i [*3] |-> shutdown_o)
    else $error("pin low, no shutdown");
  bit_default_a: assert property
    (shutdown_n_i [*3] ##0 pc > 2 && pc < PWRUP_CYC |-> !shutdown_o)
    else $error("shutdown after reset");
  busy_start_a: assert property
    ($rose(nv_write_busy_o) |-> scl_i && sda_i)
    else $error("busy before stop");
  busy_len_a: assert property ($fell(nv_write_busy_o) |->
    bc >= NVW_CYCLES - 2 && bc <= NVW_CYCLES + 4)
    else $error("busy length");
  busy_hold_a: assert property
    (nv_write_busy_o [*3] |-> $stable(wiper_o))
    else $error("wiper moved while busy");
endmodule
bind dpot_i2c_regs pot_i2c_slave_regs_sva #(.NVW_CYCLES(NVW_CYCLES),
  .PWRUP_CYC(PWRUP_CYC)) chk_u (.core_clk_i(core_clk_i),
  .rstn_i(rstn_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .addr_pin_high_i(addr_pin_high_i),
  .addr_pin_low_i(addr_pin_low_i), .shutdown_n_i(shutdown_n_i),
  .wiper_o(wiper_o), .shutdown_o(shutdown_o),
  .nv_write_busy_o(nv_write_busy_o));

//--- bench/pot_i2c_slave_regs_tb.sv
// Self-checking bench for the pot I2C slave registers
`timescale 1ns/10ps
`include "dpot_map.vh"
module pot_i2c_slave_regs_tb;
  reg         clk, rstn, ah, al, shn, ok;
  wire        scl, sdl, oe, so, busy, sh;
  wire  [6:0] nv_write_busy;
  wire        sda = !(sdl || (oe && !so));
  reg  [15:0] v;
  reg   [7:0] id, d, e;
  integer     i, bad_count, n_tests;
  dpot_i2c_regs #(.NVW_CYCLES(2000)) dut_u (
    .core_clk_i(clk), .rstn_i(rstn), .scl_i(scl), .sda_i(sda),
    .sda_o(so), .sda_oe_o(oe), .addr_pin_high_i(ah),
    .addr_pin_low_i(al), .shutdown_n_i(shn), .wiper_o(nv_write_busy),
    .shutdown_o(sh), .nv_write_busy_o(busy));
  pot_mst mst_u (.core_clk_i(clk), .sda_i(sda), .scl_o(scl),
    .sda_low_o(sdl));
  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  task chk(input string n, input [7:0] s, input [7:0] x); begin
    n_tests = n_tests + 1;
    if (s !== x) begin
      bad_count = bad_count + 1;
      $display("wrong value %s exp %h seen %h", n, x, s);
    end
  end endtask
  task stop_test; begin
    $display("%0d checks, %0d bad", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  end endtask
  task wr(input [7:0] a, input [7:0] x); begin
    mst_u.xfer(id, a, x, 1'b1, v, ok);
    repeat (4) @(posedge clk);
    chk("wr ack", ok, 8'h01);
  end endtask
  task rd(input [7:0] a, input [7:0] x); begin
    mst_u.xfer(id, a, 8'h00, 1'b0, v, ok);
    chk("rd ack", ok, 8'h01);
    chk("rd first", v[15:8], x);
    chk("rd second", v[7:0], x);
  end endtask
  initial begin
    rstn = 1'b0;
    shn = 1'b1;
    bad_count = 0;
    n_tests = 0;
    i = $urandom(76);
    {ah, al} = $urandom;
    id = {`DPOT_ID_PREFIX, ah, al, 1'b0};
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (30) @(posedge clk);
    chk("wiper", nv_write_busy, 8'h40);
    chk("shut", sh, 8'h00);
    rd(8'h02, 8'h40);
    for (i = 1; i < 8; i = i + 1) begin
      mst_u.xfer(id ^ (8'h01 << i), 8'h00, 8'h11, 1'b1, v, ok);
      chk("bad id", ok, 8'h00);
    end
    chk("wiper", nv_write_busy, 8'h40);
    $display("id test done");
    d = $urandom & 8'h7f;
    wr(8'h00, d);
    chk("busy", busy, 8'h01);
    chk("wiper", nv_write_busy, d);
    wr(8'h00, ~d);
    wr(8'h02, 8'hc0);
    chk("wiper", nv_write_busy, d);
    mst_u.xfer(id, 8'h02, 8'h00, 1'b0, v, ok);
    chk("control", v[7:0], 8'h60);
    for (i = 0; i < 9 && v[5] !== 1'b0; i = i + 1)
      mst_u.xfer(id, 8'h02, 8'h00, 1'b0, v, ok);
    if (v[5] !== 1'b0) begin
      bad_count = bad_count + 1;
      stop_test;
    end
    rd(8'h00, d);
    $display("nv test done");
    wr(8'h02, 8'hc0);
    e = $urandom & 8'h7f;
    wr(8'h00, e);
    chk("busy", busy, 8'h00);
    chk("wiper", nv_write_busy, e);
    rd(8'h00, e);
    wr(8'h01, 8'h5a);
    rd(8'h01, 8'h00);
    wr(8'h02, 8'h40);
    rd(8'h00, d);
    chk("wiper", nv_write_busy, e);
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h02, {1'b1, i[1], 6'h00});
      shn <= i[0];
      repeat (4) @(posedge clk);
      chk("shut", sh, !(i[0] && i[1]));
    end
    $display("shutdown test done");
    stop_test;
  end
endmodule
